// ---- itdio_port.sv ----
// isolated and ttl digital i/o port on the host i/o bus with one edge interrupt
// What this block does
// [R1] claim one four-byte window at the base
// [R2] base selectable 200 to 3f0 hex
// [R3] shipped selector setting gives base 300
// [R4] eight positions compare a9 down to a2
// [R5] off needs line one, on needs zero
// [R6] one irq, levels 2 to 7, or off
// [R7] interrupt on chosen rising or falling edge
// [R8] default edge is rising
// [R9] source: iso ch0/1 or ttl ch0/1
// [R10] iso byte at 0, ttl at 2,3
// [R11] every channel is one register bit
// [R12] 8+8 isolated, 16+16 ttl channels
// [R13] writing one drives the output active
// [R14] reads return input levels, not outputs
// [R15] host uses offsets 0..3; 1 is unused
// [R16] outputs latched until next write there
module itdio_port (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // host i/o bus, synchronous to the clock
    input wire logic [itdio_pkg::ADDR_W-1:0] addr_i,
    input wire logic aen_i,
    input wire logic ior_n_i,
    input wire logic iow_n_i,
    input wire logic [itdio_pkg::DATA_W-1:0] data_i,
    output logic [itdio_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic board_sel_o,
    // switch and jumper settings
    input wire logic [itdio_pkg::SEL_W-1:0] base_address_selector_i,
    input wire logic [2:0] irq_line_selector_i,
    input wire logic [1:0] irq_source_selector_i,
    input wire logic irq_edge_selector_i,
    // field channels
    input wire logic [itdio_pkg::ISO_W-1:0] iso_in_i,
    input wire logic [itdio_pkg::TTL_W-1:0] ttl_in_i,
    output logic [itdio_pkg::ISO_W-1:0] iso_out_o,
    output logic [itdio_pkg::TTL_W-1:0] ttl_out_o,
    // interrupt request lines for levels 2 to 7, bit 0 is level 2
    output logic [itdio_pkg::IRQ_W-1:0] irq_o
);
    // base address from selector positions: an on position forces a zero line
    function automatic logic [itdio_pkg::ADDR_W-1:0] sel_to_base(
        input logic [itdio_pkg::SEL_W-1:0] sel
    );
        sel_to_base = {~sel, 2'b00}; // [R4] [R5]
    endfunction

    // one bit per line level 2..7; codes outside the range give no line
    function automatic logic [itdio_pkg::IRQ_W-1:0] line_onehot(input logic [2:0] code);
        logic [itdio_pkg::IRQ_W-1:0] oh;
        oh = '0;
        if (code >= itdio_pkg::IRQ_LINE_MIN && code <= itdio_pkg::IRQ_LINE_MAX) begin
            oh[3'(code - itdio_pkg::IRQ_LINE_MIN)] = 1'b1; // [R6]
        end
        line_onehot = oh;
    endfunction

    // address decode
    wire logic [itdio_pkg::ADDR_W-1:0] base_w = sel_to_base(base_address_selector_i);
    wire logic base_legal_w = (base_w >= itdio_pkg::BASE_MIN) && (base_w <= itdio_pkg::BASE_MAX); // [R2] [R3]
    wire logic sel_match_w =
        (addr_i[itdio_pkg::SEL_MSB:itdio_pkg::SEL_LSB] == ~base_address_selector_i); // [R4] [R5]
    wire logic hit_w = ~aen_i & sel_match_w & base_legal_w; // [R1]
    wire logic [1:0] ofs_w = addr_i[itdio_pkg::OFS_MSB:itdio_pkg::OFS_LSB];

    // write strobe on the falling edge of the write line
    logic iow_prev_reg;
    wire logic wr_w = hit_w & iow_prev_reg & ~iow_n_i;
    wire logic wr_iso_w = wr_w & (ofs_w == itdio_pkg::OFS_ISO_IO); // [R10]
    wire logic wr_tlo_w = wr_w & (ofs_w == itdio_pkg::OFS_TTL_LO); // [R10]
    wire logic wr_thi_w = wr_w & (ofs_w == itdio_pkg::OFS_TTL_HI); // [R10]
    wire logic rd_w = hit_w & ~ior_n_i;

    // output latches, each channel one bit
    logic [itdio_pkg::ISO_W-1:0] iso_out_reg;
    logic [itdio_pkg::DATA_W-1:0] ttl_lo_reg;
    logic [itdio_pkg::DATA_W-1:0] ttl_hi_reg;
    wire logic [itdio_pkg::ISO_W-1:0] iso_out_next = wr_iso_w ? data_i : iso_out_reg; // [R13] [R16]
    wire logic [itdio_pkg::DATA_W-1:0] ttl_lo_next = wr_tlo_w ? data_i : ttl_lo_reg; // [R13] [R16]
    wire logic [itdio_pkg::DATA_W-1:0] ttl_hi_next = wr_thi_w ? data_i : ttl_hi_reg; // [R13] [R16]

    // read data: live input levels, offset 1 reads zero
    wire logic [itdio_pkg::DATA_W-1:0] rd_mux_w =
        (ofs_w == itdio_pkg::OFS_ISO_IO) ? iso_in_i :
        (ofs_w == itdio_pkg::OFS_TTL_LO) ? ttl_in_i[itdio_pkg::DATA_W-1:0] :
        (ofs_w == itdio_pkg::OFS_TTL_HI) ? ttl_in_i[itdio_pkg::TTL_W-1:itdio_pkg::DATA_W] :
        itdio_pkg::READ_UNUSED; // [R14] [R11] [R15]

    logic [itdio_pkg::DATA_W-1:0] data_reg;
    logic data_oe_reg;
    logic board_sel_reg;

    // bus side flops
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            iow_prev_reg <= 1'b1;
            data_reg <= itdio_pkg::READ_UNUSED;
            data_oe_reg <= 1'b0;
            board_sel_reg <= 1'b0;
        end else begin
            iow_prev_reg <= iow_n_i;
            data_reg <= rd_w ? rd_mux_w : itdio_pkg::READ_UNUSED;
            data_oe_reg <= rd_w;
            board_sel_reg <= hit_w & (~ior_n_i | ~iow_n_i);
        end
    end

    // output latches
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            iso_out_reg <= itdio_pkg::ISO_OUT_RST;
            ttl_lo_reg <= itdio_pkg::TTL_BYTE_RST;
            ttl_hi_reg <= itdio_pkg::TTL_BYTE_RST;
        end else begin
            iso_out_reg <= iso_out_next; // [R12]
            ttl_lo_reg <= ttl_lo_next;
            ttl_hi_reg <= ttl_hi_next;
        end
    end

    // interrupt source pick
    wire logic src_w =
        (irq_source_selector_i == itdio_pkg::SRC_ISO_CH0) ? iso_in_i[0] :
        (irq_source_selector_i == itdio_pkg::SRC_ISO_CH1) ? iso_in_i[1] :
        (irq_source_selector_i == itdio_pkg::SRC_TTL_CH0) ? ttl_in_i[0] :
        ttl_in_i[1]; // [R9]
    wire logic [itdio_pkg::IRQ_W-1:0] line_oh_w = line_onehot(irq_line_selector_i);
    wire logic irq_en_w = (line_oh_w != '0); // [R6]
    logic pulse_w;

    // edge detection and pulse shaping
    itdio_irq_gen u_irq_gen (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .src_i(src_w),
        .falling_i(irq_edge_selector_i), // [R7] [R8]
        .enable_i(irq_en_w),
        .pulse_o(pulse_w)
    );

    // drive only the selected level
    logic [itdio_pkg::IRQ_W-1:0] irq_reg;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= line_oh_w & {itdio_pkg::IRQ_W{pulse_w}}; // [R6]
        end
    end

    assign data_o = data_reg;
    assign data_oe_o = data_oe_reg;
    assign board_sel_o = board_sel_reg;
    assign iso_out_o = iso_out_reg;
    assign ttl_out_o = {ttl_hi_reg, ttl_lo_reg};
    assign irq_o = irq_reg;
endmodule

// ---- itdio_pkg.sv ----
// constants, offsets and selector encodings of the isolated/ttl digital i/o port
package itdio_pkg;
    // host address and data widths, selector, channel and interrupt line widths
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int SEL_W = 8;
    localparam int ISO_W = 8;
    localparam int TTL_W = 16;
    localparam int IRQ_W = 6;
    // register offsets inside the four-byte window
    localparam logic [1:0] OFS_ISO_IO = 2'h0;
    localparam logic [1:0] OFS_UNUSED = 2'h1;
    localparam logic [1:0] OFS_TTL_LO = 2'h2;
    localparam logic [1:0] OFS_TTL_HI = 2'h3;
    // address line slice compared against the selector, and the offset slice
    localparam int SEL_MSB = 9;
    localparam int SEL_LSB = 2;
    localparam int OFS_MSB = 1;
    localparam int OFS_LSB = 0;
    // legal window of base addresses
    localparam logic [ADDR_W-1:0] BASE_MIN = 10'h200;
    localparam logic [ADDR_W-1:0] BASE_MAX = 10'h3f0;
    // selector positions as shipped: 1 and 2 off, the rest on, base 300
    localparam logic [SEL_W-1:0] BASE_SEL_DEFAULT = 8'h3f;
    // interrupt line selector codes: 0 disables, 2..7 pick the level
    localparam logic [2:0] IRQ_LINE_OFF = 3'h0;
    localparam logic [2:0] IRQ_LINE_MIN = 3'h2;
    localparam logic [2:0] IRQ_LINE_MAX = 3'h7;
    // interrupt source selector codes
    localparam logic [1:0] SRC_ISO_CH0 = 2'h0;
    localparam logic [1:0] SRC_ISO_CH1 = 2'h1;
    localparam logic [1:0] SRC_TTL_CH0 = 2'h2;
    localparam logic [1:0] SRC_TTL_CH1 = 2'h3;
    // edge selector: 0 rising (default), 1 falling
    localparam logic EDGE_RISING = 1'b0;
    localparam logic EDGE_FALLING = 1'b1;
    // reset values of the output latches, and the read value of the unused offset
    localparam logic [ISO_W-1:0] ISO_OUT_RST = 8'h00;
    localparam logic [DATA_W-1:0] TTL_BYTE_RST = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNUSED = 8'h00;
    // interrupt pulse length, time and clock
    localparam int CLK_PERIOD_NS = 5;
    localparam int IRQ_PULSE_NS = 20;
    localparam int IRQ_PULSE_CYC_I = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] IRQ_PULSE_CYC = 4'(IRQ_PULSE_CYC_I);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
endpackage

// ---- itdio_irq_gen.sv ----
// edge detector and fixed-length interrupt pulse for the selected source input
module itdio_irq_gen (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic src_i,
    input wire logic falling_i,
    input wire logic enable_i,
    output logic pulse_o
);
    logic prev_reg;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic pulse_reg;
    logic arm_reg; // low for the first sample after reset
    wire logic rise_w = src_i & ~prev_reg;
    wire logic fall_w = ~src_i & prev_reg;
    // pick the edge that triggers; a disabled line never fires
    // the first sample after reset only primes prev_reg, so a pulled-up input fakes no edge
    wire logic event_w = enable_i & arm_reg &
        ((falling_i == itdio_pkg::EDGE_FALLING) ? fall_w : rise_w); // [R7]

    // a fresh edge restarts the pulse, otherwise count it down
    assign cnt_next = event_w ? itdio_pkg::IRQ_PULSE_CYC :
                      (cnt_reg != itdio_pkg::CNT_ZERO) ? cnt_reg - itdio_pkg::CNT_ONE :
                      itdio_pkg::CNT_ZERO;

    // previous level, pulse counter and pulse flop
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
            arm_reg <= 1'b0;
            cnt_reg <= itdio_pkg::CNT_ZERO;
            pulse_reg <= 1'b0;
        end else begin
            prev_reg <= src_i;
            arm_reg <= 1'b1;
            cnt_reg <= cnt_next;
            pulse_reg <= (cnt_next != itdio_pkg::CNT_ZERO);
        end
    end

    assign pulse_o = pulse_reg;
endmodule

// ---- itdio_port_monitor.sv ----
// checker on the ports of the digital i/o port
module itdio_port_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [9:0] addr_i,
    input wire logic aen_i,
    input wire logic ior_n_i,
    input wire logic iow_n_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe_o,
    input wire logic board_sel_o,
    input wire logic [7:0] base_address_selector_i,
    input wire logic [2:0] irq_line_selector_i,
    input wire logic [1:0] irq_source_selector_i,
    input wire logic irq_edge_selector_i,
    input wire logic [7:0] iso_in_i,
    input wire logic [15:0] ttl_in_i,
    input wire logic [7:0] iso_out_o,
    input wire logic [15:0] ttl_out_o,
    input wire logic [5:0] irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic iow_q;
    logic src_q;
    logic arm_q;
    // address decode, expected read data and the selected interrupt source
    wire logic [7:0] blk = addr_i[9:2];
    wire logic hit = !aen_i && blk == ~base_address_selector_i && blk[7] && blk <= 8'hfc;
    wire logic rd = hit && !ior_n_i;
    wire logic wr = hit && !iow_n_i && iow_q;
    wire logic [1:0] ofs = addr_i[1:0];
    wire logic [7:0] rd_val = ofs == 2'h0 ? iso_in_i : ofs == 2'h1 ? 8'h00 :
        ofs[0] ? ttl_in_i[15:8] : ttl_in_i[7:0];
    wire logic [15:0] ttl_wr = ofs[0] ? {data_i, ttl_out_o[7:0]} : {ttl_out_o[15:8], data_i};
    wire logic [2:0] lvl = irq_line_selector_i;
    wire logic src = irq_source_selector_i[1] ? ttl_in_i[irq_source_selector_i[0]] :
        iso_in_i[irq_source_selector_i[0]];
    wire logic trig = arm_q && lvl >= 3'h2 && src != src_q && src != irq_edge_selector_i;
    // previous strobe and source samples
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            iow_q <= 1'b1;
            src_q <= 1'b0;
            arm_q <= 1'b0;
        end else begin
            iow_q <= iow_n_i;
            src_q <= src;
            arm_q <= 1'b1;
        end
    end
    a_read_claim: assert property (rd |=> data_oe_o && board_sel_o)
        else $error("claimed read not answered");
    a_no_claim: assert property (!rd |=> !data_oe_o)
        else $error("bus driven without claim");
    a_read_data: assert property (rd |=> data_o == $past(rd_val))
        else $error("wrong read data");
    a_write_iso: assert property (wr && ofs == 2'h0 |=> iso_out_o == $past(data_i))
        else $error("isolated outputs not written");
    a_write_ttl: assert property (wr && ofs[1] |=> ttl_out_o == $past(ttl_wr))
        else $error("ttl outputs not written");
    a_out_hold: assert property (!wr || ofs == 2'h1 |=> $stable({iso_out_o, ttl_out_o}))
        else $error("outputs changed without write");
    a_irq_edge: assert property (trig |-> ##[2:3] irq_o[lvl - 3'h2])
        else $error("edge raised no interrupt");
    a_irq_line: assert property (|irq_o |-> lvl >= 3'h2 && irq_o == 6'h1 << (lvl - 3'h2))
        else $error("interrupt on wrong line");
    a_irq_width: assert property ($rose(|irq_o) |-> (|irq_o) [*4] ##1 !(|irq_o))
        else $error("interrupt pulse length wrong");
    a_write_sel: assert property (wr |=> board_sel_o)
        else $error("claimed write not flagged");
    a_sel_idle: assert property (!hit |=> !board_sel_o)
        else $error("board selected without claim");
endmodule

// ---- itdio_host.sv ----
// host processor model driving the i/o bus
module itdio_host (
    input wire logic ref_clk_i,
    output logic [9:0] addr_o = 10'h000,
    output logic aen_o = 1'b0,
    output logic ior_n_o = 1'b1,
    output logic iow_n_o = 1'b1,
    output logic [7:0] data_o = 8'h00,
    input wire logic [7:0] data_i,
    input wire logic data_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // write cycle, strobe low over two edges, data line released inverted
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic e);
        @(posedge ref_clk_i);
        #1;
        addr_o = a;
        aen_o = e;
        data_o = d;
        iow_n_o = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        iow_n_o = 1'b1;
        aen_o = 1'b0;
        data_o = ~d;
    endtask
    // read cycle, answer taken after the second edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
        @(posedge ref_clk_i);
        #1;
        addr_o = a;
        ior_n_o = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        d = data_i;
        oe = data_oe_i;
        ior_n_o = 1'b1;
    endtask
endmodule

// ---- test_itdio_port.sv ----
// self-checking bench for the digital i/o port
module test_itdio_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [9:0] addr_i;
    logic aen_i, ior_n_i, iow_n_i, data_oe_o, board_sel_o;
    logic [7:0] data_i, data_o, iso_out_o;
    logic [7:0] base_address_selector_i = 8'h3f;
    logic [2:0] irq_line_selector_i = 3'h0;
    logic [1:0] irq_source_selector_i = 2'h0;
    logic irq_edge_selector_i = 1'b0;
    logic [7:0] iso_in_i = 8'h00;
    logic [15:0] ttl_in_i = 16'h0000;
    logic [15:0] ttl_out_o;
    logic [5:0] irq_o;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    itdio_port i_itdio_port (.*);
    itdio_host i_itdio_host (.ref_clk_i(ref_clk_i), .addr_o(addr_i), .aen_o(aen_i),
        .ior_n_o(ior_n_i), .iow_n_o(iow_n_i), .data_o(data_i), .data_i(data_o),
        .data_oe_i(data_oe_o));
    // clock and hang guard
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 2000) begin
            miscompares++;
            finish_test();
        end
    end
    // shared compare
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // writes at the shipped base, reads return inputs
    task automatic t_regs();
        logic [7:0] rexp [4] = '{8'h96, 8'h00, 8'h81, 8'h7e};
        logic [7:0] d;
        logic e;
        i_itdio_host.wr(10'h300, 8'ha5, 1'b0);
        i_itdio_host.wr(10'h302, 8'h3c, 1'b0);
        i_itdio_host.wr(10'h303, 8'hc3, 1'b0);
        i_itdio_host.wr(10'h301, 8'hff, 1'b0);
        i_itdio_host.wr(10'h300, 8'h5a, 1'b1);
        chk({ttl_out_o, iso_out_o}, 24'hc33ca5);
        iso_in_i = 8'h96;
        ttl_in_i = 16'h7e81;
        for (int k = 0; k < 4; k++) begin
            i_itdio_host.rd(10'h300 + 10'(k), d, e);
            chk({e, d}, {1'b1, rexp[k]});
        end
        i_itdio_host.rd(10'h304, d, e);
        chk({e, d}, 24'h0);
    endtask
    // window ends and a base above the legal range
    task automatic t_base();
        logic [9:0] b [3] = '{10'h200, 10'h3f0, 10'h3f4};
        logic [7:0] s [3] = '{8'h7f, 8'h03, 8'h02};
        logic [7:0] x [3] = '{8'h11, 8'h22, 8'h22};
        for (int k = 0; k < 3; k++) begin
            base_address_selector_i = s[k];
            i_itdio_host.wr(b[k], 8'h11 << k, 1'b0);
            i_itdio_host.wr(10'h300, 8'hee, 1'b0);
            chk(iso_out_o, x[k]);
        end
        base_address_selector_i = 8'h3f;
    endtask
    // every line code, source and edge; irq_o low just before each edge
    task automatic t_irq();
        logic [5:0] acc;
        for (int k = 0; k < 8; k++) begin
            irq_line_selector_i = 3'(k);
            irq_source_selector_i = 2'(k);
            irq_edge_selector_i = k[2];
            iso_in_i = {8{k[2]}};
            ttl_in_i = {16{k[2]}};
            repeat (8) @(posedge ref_clk_i);
            #1;
            chk(irq_o, 6'h0);
            iso_in_i = ~iso_in_i;
            ttl_in_i = ~ttl_in_i;
            acc = 6'h0;
            repeat (8) begin
                @(posedge ref_clk_i);
                #1;
                acc = acc | irq_o;
            end
            chk(acc, k > 1 ? 6'h1 << (k - 2) : 6'h0);
        end
    endtask
    // or of irq_o over eight cycles, sampled just after each edge
    task automatic irq_seen(output logic [5:0] acc);
        acc = 6'h0;
        repeat (8) begin
            @(posedge ref_clk_i);
            #1;
            acc = acc | irq_o;
        end
    endtask
    // mid-run reset clears outputs; an input high at release fakes no edge
    task automatic t_reset();
        logic [5:0] acc;
        rst_n_i = 1'b0;
        irq_line_selector_i = 3'h2;
        irq_source_selector_i = 2'h2;
        irq_edge_selector_i = 1'b0;
        ttl_in_i = 16'hffff;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk({ttl_out_o, iso_out_o}, 24'h0);
        chk({irq_o, data_oe_o, board_sel_o, data_o}, 24'h0);
        rst_n_i = 1'b1;
        irq_seen(acc);
        chk(acc, 6'h0);
        ttl_in_i = 16'h0000;
        irq_seen(acc);
        chk(acc, 6'h0);
        ttl_in_i = 16'hffff;
        irq_seen(acc);
        chk(acc, 6'h1);
    endtask
    // verdict
    task automatic finish_test();
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        t_regs();
        t_base();
        t_irq();
        t_reset();
        finish_test();
    end
endmodule
bind itdio_port itdio_port_monitor i_itdio_port_monitor (.*);
